// ---- general_purpose_timer.sv ----
`timescale 1ns/10ps
`default_nettype none

// Functional notes
// - the counter is 16 bits, auto-reloads, and counts up, down or up/down alternately.
// - a 16-bit prescaler divides the counter clock by any integer from 1 to 65536.
// - the four-channel build has four channels: capture, compare, pwm or one-pulse.
// - the two-channel build has two channels with the same four functions.
// - the four-channel build raises dma requests; the two-channel build raises none.
// - a trigger output and a trigger input let timers sync counters or chain events.
// - while the cpu is halted in debug and freeze is set, the counter stops stepping; a hall or trigger reset still clears it.
// - the four-channel build decodes a quadrature encoder and up to three hall sensors.
// - the two-channel build can count the low-speed external clock as a time base.
// - the channels have no complementary output pairs.
module general_purpose_timer #(
    parameter int NUM_CH      = 4,
    parameter bit HAS_DMA     = 1'b1,
    parameter bit HAS_ENCODER = 1'b1,
    parameter bit HAS_LOWSPD  = 1'b0,
    parameter int CNT_W       = 16
) (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              rst_n,
    // apb slave
    input  wire logic [7:0]        paddr,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // channel pins
    input  wire logic [NUM_CH-1:0] ch_in,
    output logic      [NUM_CH-1:0] ch_out,
    input  wire logic [2:0]        hall_in,
    // clocks, timer link and debug
    input  wire logic              low_speed_external_clock,
    input  wire logic              trig_in,
    output logic                   trig_out,
    input  wire logic              dbg_halt,
    // dma requests
    output logic                   dma_req_update,
    output logic      [NUM_CH-1:0] dma_req_cc
);

    // ************************************
    // state
    // ************************************
    gpt_pkg::ctrl_s    ctrl_q, ctrl_d;
    logic [CNT_W-1:0]  cnt_q, cnt_d, arr_q, arr_d;
    logic [15:0]       psc_q, psc_d, pcnt_q, pcnt_d;
    logic              cdown_q, cdown_d;
    logic              upd_q, upd_d;
    logic [NUM_CH-1:0] ccf_q, ccf_d;
    logic [NUM_CH:0]   dmaen_q, dmaen_d;
    logic [CNT_W-1:0]  ccr_q [NUM_CH];
    logic [CNT_W-1:0]  ccr_d [NUM_CH];
    gpt_pkg::ch_mode_e mode_q [NUM_CH];
    gpt_pkg::ch_mode_e mode_d [NUM_CH];
    logic [NUM_CH-1:0] out_q, out_d, in_q, in_p;
    logic [2:0]        hall_q, hall_p;
    logic              lsc_q, lsc_p, trg_q, trg_p;
    logic [31:0]       rdata_q, rdata_d;
    logic              trgo_q, trgo_d, dupd_q, dupd_d;
    logic [NUM_CH-1:0] dcc_q, dcc_d;

    // ************************************
    // combinational helpers
    // ************************************
    logic              wr, setup, unmapped, src_tick, step, run;
    logic              down, upd_ev, enc_step, enc_down;
    logic              lsc_rise, trg_rise, hall_edge;
    logic [NUM_CH-1:0] cap_ev, hit_ev;
    logic [31:0]       cap_r;
    int                ci;

    // channel index of a compare register address, -1 when none
    function automatic int ccr_index(input logic [7:0] a);
        int k;
        k = -1;
        for (int i = 0; i < NUM_CH; i++) begin
            if (a == gpt_pkg::OFF_CCR0 + 8'(i * gpt_pkg::CCR_STEP)) begin
                k = i;
            end
        end
        return k;
    endfunction

    // zero-wait slave: data is latched in setup and shown in access
    assign pready  = 1'b1;
    assign pslverr = psel & penable & unmapped;
    assign prdata  = rdata_q;
    assign ch_out  = out_q;
    assign trig_out = trgo_q;
    assign dma_req_update = dupd_q;
    assign dma_req_cc = dcc_q;

    // ************************************
    // address decode and read data
    // ************************************
    always_comb begin
        ci       = ccr_index(paddr);
        setup    = psel & ~penable;
        unmapped = 1'b0;
        cap_r    = '0;
        rdata_d  = rdata_q;
        if (paddr == gpt_pkg::OFF_CTRL) begin
            cap_r = 32'(ctrl_q);
        end else if (paddr == gpt_pkg::OFF_STATUS) begin
            cap_r = 32'({ccf_q, upd_q});
        end else if (paddr == gpt_pkg::OFF_CNT) begin
            cap_r = 32'(cnt_q);
        end else if (paddr == gpt_pkg::OFF_PSC) begin
            cap_r = 32'(psc_q);
        end else if (paddr == gpt_pkg::OFF_ARR) begin
            cap_r = 32'(arr_q);
        end else if (paddr == gpt_pkg::OFF_CHMODE) begin
            for (int i = 0; i < NUM_CH; i++) begin
                cap_r[i*gpt_pkg::MODE_W +: gpt_pkg::MODE_W] = mode_q[i];
            end
        end else if (paddr == gpt_pkg::OFF_DMAEN) begin
            cap_r = 32'(dmaen_q);
        end else if (ci >= 0) begin
            cap_r = 32'(ccr_q[ci]);
        end else begin
            unmapped = 1'b1;
        end
        if (setup && !pwrite) begin
            rdata_d = cap_r;
        end
        wr = psel & penable & pwrite & ~unmapped;
    end

    // ************************************
    // input edges, encoder and tick source
    // ************************************
    always_comb begin
        lsc_rise  = lsc_q & ~lsc_p;
        trg_rise  = trg_q & ~trg_p;
        hall_edge = HAS_ENCODER & ctrl_q.hall_en & ((^hall_q) != (^hall_p));
        cap_ev    = in_q & ~in_p;
        // x4 quadrature: direction from new a against old b
        enc_step  = HAS_ENCODER & ctrl_q.enc_en &
                    ((in_q[0] ^ in_p[0]) | (in_q[1] ^ in_p[1]));
        enc_down  = ~(in_q[0] ^ in_p[1]);
        case (ctrl_q.clk_src)
            gpt_pkg::CLK_INT:      src_tick = 1'b1;
            gpt_pkg::CLK_LOWSPEED: src_tick = HAS_LOWSPD & lsc_rise;
            gpt_pkg::CLK_TRIG:     src_tick = trg_rise;
            default:               src_tick = 1'b0;
        endcase
        // freeze only stops counting; registers stay reachable
        run = ctrl_q.enable & ~(ctrl_q.dbg_freeze & dbg_halt);
    end

    // ************************************
    // prescaler, counter and direction
    // ************************************
    always_comb begin
        ctrl_d  = ctrl_q;
        psc_d   = psc_q;
        arr_d   = arr_q;
        cnt_d   = cnt_q;
        pcnt_d  = pcnt_q;
        cdown_d = cdown_q;
        upd_ev  = 1'b0;
        step    = 1'b0;
        // divide by psc+1, so 0..ffff gives 1..65536
        if (run && (ctrl_q.enc_en ? enc_step : src_tick)) begin
            if (ctrl_q.enc_en || pcnt_q == psc_q) begin
                pcnt_d = '0;
                step   = 1'b1;
            end else begin
                pcnt_d = pcnt_q + 16'h0001;
            end
        end
        if (ctrl_q.enc_en) begin
            down = enc_down;
        end else if (ctrl_q.center) begin
            down = cdown_q;
        end else begin
            down = ctrl_q.dir_down;
        end
        if (step) begin
            if (ctrl_q.center && !ctrl_q.enc_en) begin
                // up/down: turn at arr and at zero, update at both ends
                if (!down && cnt_q == arr_q) begin
                    cdown_d = 1'b1;
                    cnt_d   = cnt_q - 1'b1;
                    upd_ev  = 1'b1;
                end else if (down && cnt_q == '0) begin
                    cdown_d = 1'b0;
                    cnt_d   = cnt_q + 1'b1;
                    upd_ev  = 1'b1;
                end else begin
                    cnt_d = down ? cnt_q - 1'b1 : cnt_q + 1'b1;
                end
            end else if (down) begin
                upd_ev = (cnt_q == '0);
                cnt_d  = upd_ev ? arr_q : cnt_q - 1'b1;
            end else begin
                upd_ev = (cnt_q == arr_q);
                cnt_d  = upd_ev ? '0 : cnt_q + 1'b1;
            end
        end
        // chained reset from a peer or a hall transition
        if ((ctrl_q.trig_rst && trg_rise) || hall_edge) begin
            cnt_d  = '0;
            pcnt_d = '0;
        end
        if (wr && paddr == gpt_pkg::OFF_CTRL) begin
            ctrl_d = gpt_pkg::ctrl_s'(pwdata[gpt_pkg::CTRL_W-1:0]);
        end else if (ctrl_q.opm && upd_ev) begin
            ctrl_d.enable = 1'b0;
        end
        if (wr && paddr == gpt_pkg::OFF_CNT) begin
            cnt_d  = pwdata[CNT_W-1:0];
        end
        if (wr && paddr == gpt_pkg::OFF_PSC) begin
            psc_d  = pwdata[15:0];
            pcnt_d = '0;
        end
        if (wr && paddr == gpt_pkg::OFF_ARR) begin
            arr_d  = pwdata[CNT_W-1:0];
        end
    end

    // ************************************
    // channels, flags and requests
    // ************************************
    always_comb begin
        upd_d   = upd_q;
        ccf_d   = ccf_q;
        dmaen_d = dmaen_q;
        out_d   = out_q;
        hit_ev  = '0;
        for (int i = 0; i < NUM_CH; i++) begin
            ccr_d[i]  = ccr_q[i];
            mode_d[i] = mode_q[i];
        end
        // status is write-one-to-clear, a same-cycle event wins
        if (wr && paddr == gpt_pkg::OFF_STATUS) begin
            upd_d = upd_q & ~pwdata[gpt_pkg::STS_UPD_BIT];
            ccf_d = ccf_q & ~pwdata[gpt_pkg::STS_CC_LSB +: NUM_CH];
        end
        if (upd_ev) begin
            upd_d = 1'b1;
        end
        for (int i = 0; i < NUM_CH; i++) begin
            if (wr && paddr == gpt_pkg::OFF_CHMODE) begin
                mode_d[i] = gpt_pkg::ch_mode_e'(pwdata[i*gpt_pkg::MODE_W +: gpt_pkg::MODE_W]);
            end
            if (wr && ccr_index(paddr) == i) begin
                ccr_d[i] = pwdata[CNT_W-1:0];
            end
            // each channel is a single output; no inverted twin exists
            case (mode_q[i])
                gpt_pkg::CH_CAPTURE: begin
                    out_d[i] = 1'b0;
                    if (cap_ev[i] || (i == 0 && hall_edge)) begin
                        ccr_d[i]  = cnt_q;
                        hit_ev[i] = 1'b1;
                    end
                end
                gpt_pkg::CH_COMPARE: begin
                    hit_ev[i] = step & (cnt_d == ccr_q[i]);
                    if (hit_ev[i]) begin
                        out_d[i] = ~out_q[i];
                    end
                end
                gpt_pkg::CH_PWM: begin
                    hit_ev[i] = step & (cnt_d == ccr_q[i]);
                    out_d[i]  = (cnt_d < ccr_q[i]);
                end
                default: begin
                    // one pulse: active from match until update
                    hit_ev[i] = step & (cnt_d == ccr_q[i]);
                    if (hit_ev[i]) begin
                        out_d[i] = 1'b1;
                    end else if (upd_ev) begin
                        out_d[i] = 1'b0;
                    end
                end
            endcase
            if (hit_ev[i]) begin
                ccf_d[i] = 1'b1;
            end
        end
        if (wr && paddr == gpt_pkg::OFF_DMAEN) begin
            dmaen_d = pwdata[NUM_CH:0];
        end
        trgo_d = upd_ev;
        dupd_d = HAS_DMA & upd_ev & dmaen_q[gpt_pkg::STS_UPD_BIT];
        dcc_d  = HAS_DMA ? (hit_ev & dmaen_q[gpt_pkg::STS_CC_LSB +: NUM_CH]) : '0;
    end

    // ************************************
    // registers
    // ************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q  <= gpt_pkg::CTRL_RST;
            cnt_q   <= CNT_W'(gpt_pkg::CNT_RST);
            arr_q   <= CNT_W'(gpt_pkg::ARR_RST);
            psc_q   <= gpt_pkg::PSC_RST;
            pcnt_q  <= '0;
            cdown_q <= 1'b0;
            upd_q   <= 1'b0;
            ccf_q   <= '0;
            dmaen_q <= '0;
            out_q   <= '0;
            in_q    <= '0;
            in_p    <= '0;
            hall_q  <= '0;
            hall_p  <= '0;
            lsc_q   <= 1'b0;
            lsc_p   <= 1'b0;
            trg_q   <= 1'b0;
            trg_p   <= 1'b0;
            rdata_q <= '0;
            trgo_q  <= 1'b0;
            dupd_q  <= 1'b0;
            dcc_q   <= '0;
            for (int i = 0; i < NUM_CH; i++) begin
                ccr_q[i]  <= '0;
                mode_q[i] <= gpt_pkg::CH_CAPTURE;
            end
        end else begin
            ctrl_q  <= ctrl_d;
            cnt_q   <= cnt_d;
            arr_q   <= arr_d;
            psc_q   <= psc_d;
            pcnt_q  <= pcnt_d;
            cdown_q <= cdown_d;
            upd_q   <= upd_d;
            ccf_q   <= ccf_d;
            dmaen_q <= dmaen_d;
            out_q   <= out_d;
            in_q    <= ch_in;
            in_p    <= in_q;
            hall_q  <= hall_in;
            hall_p  <= hall_q;
            lsc_q   <= low_speed_external_clock;
            lsc_p   <= lsc_q;
            trg_q   <= trig_in;
            trg_p   <= trg_q;
            rdata_q <= rdata_d;
            trgo_q  <= trgo_d;
            dupd_q  <= dupd_d;
            dcc_q   <= dcc_d;
            for (int i = 0; i < NUM_CH; i++) begin
                ccr_q[i]  <= ccr_d[i];
                mode_q[i] <= mode_d[i];
            end
        end
    end

endmodule
`default_nettype wire

// ---- gpt_pkg.sv ----
`default_nettype none
package gpt_pkg;

    // ************************************
    // register map (byte addresses)
    // ************************************
    localparam logic [7:0] OFF_CTRL   = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_CNT    = 8'h08;
    localparam logic [7:0] OFF_PSC    = 8'h0c;
    localparam logic [7:0] OFF_ARR    = 8'h10;
    localparam logic [7:0] OFF_CHMODE = 8'h14;
    localparam logic [7:0] OFF_DMAEN  = 8'h18;
    localparam logic [7:0] OFF_CCR0   = 8'h20;
    localparam int         CCR_STEP   = 4;

    // ************************************
    // field positions and reset values
    // ************************************
    localparam int          STS_UPD_BIT = 0;
    localparam int          STS_CC_LSB  = 1;
    localparam int          CTRL_W      = 10;
    localparam int          MODE_W      = 2;
    localparam logic [15:0] PSC_RST     = 16'h0000;
    localparam logic [15:0] ARR_RST     = 16'hffff;
    localparam logic [15:0] CNT_RST     = 16'h0000;

    // counter clock source
    typedef enum logic [1:0] {
        CLK_INT,
        CLK_LOWSPEED,
        CLK_TRIG
    } clk_src_e;

    // per-channel function
    typedef enum logic [1:0] {
        CH_CAPTURE,
        CH_COMPARE,
        CH_PWM,
        CH_ONEPULSE
    } ch_mode_e;

    // control register layout, lsb last
    typedef struct packed {
        clk_src_e clk_src;
        logic     trig_rst;
        logic     enc_en;
        logic     hall_en;
        logic     dbg_freeze;
        logic     opm;
        logic     center;
        logic     dir_down;
        logic     enable;
    } ctrl_s;

    localparam ctrl_s CTRL_RST = '0;

endpackage
`default_nettype wire

// ---- gpt_sva.sv ----
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// port-level checks for the timer
// ****************************************
module gpt_sva #(
    parameter int NUM_CH = 4
) (
    // clock and reset
    input wire logic              clk,
    input wire logic              rst_n,
    // apb side
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    // pins and requests
    input wire logic [NUM_CH-1:0] ch_out,
    input wire logic              trig_out,
    input wire logic              dma_req_update,
    input wire logic [NUM_CH-1:0] dma_req_cc
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // link, update request and channel 0 dma strobes are single-cycle pulses
    a_trig_one_cycle: assert property (trig_out |=> !trig_out)
        else $error("link pulse longer than one cycle");
    a_upd_req_pulse: assert property (dma_req_update |=> !dma_req_update)
        else $error("update request longer than one cycle");
    a_cc_req_pulse: assert property (dma_req_cc[0] |=> !dma_req_cc[0])
        else $error("channel request longer than one cycle");
    // the update request rides on the same update as the link pulse
    a_req_with_link: assert property (dma_req_update |-> trig_out)
        else $error("update request without link pulse");
    // zero wait states, error only inside an access
    a_ready_in_access: assert property (psel && penable |-> pready)
        else $error("no ready in access phase");
    a_err_in_access: assert property (pslverr |-> psel && penable)
        else $error("error outside access phase");
    // outputs come out of reset quiet
    a_quiet_release: assert property ($rose(rst_n) |-> ch_out == '0 && !trig_out)
        else $error("outputs busy right after reset");
    // read data only moves after a read setup
    a_rdata_holds: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
        else $error("read data moved without a read");
endmodule

bind general_purpose_timer gpt_sva #(.NUM_CH(NUM_CH)) u_sva (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .ch_out(ch_out),
    .trig_out(trig_out), .dma_req_update(dma_req_update), .dma_req_cc(dma_req_cc));
`default_nettype wire

// ---- gpt_partner.sv ----
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// encoder and peer timer model
// ****************************************
module gpt_partner (
    // clock and command
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       go,
    // encoder phases and link pulse
    output logic      [1:0] ab,
    output logic            trig
);
    logic [2:0] left_q, left_d;
    logic [1:0] div_q, div_d, ph_q, ph_d;

    // four slow steps per go, slow enough for the input synchronisers
    always_comb begin
        left_d = go ? 3'h4 : left_q;
        div_d  = div_q;
        ph_d   = ph_q;
        if (left_q != 3'h0) begin
            div_d = div_q + 2'h1;
            if (div_q == 2'h3) begin
                ph_d   = ph_q + 2'h1;
                left_d = left_q - 3'h1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            {left_q, div_q, ph_q} <= '0;
        end else begin
            {left_q, div_q, ph_q} <= {left_d, div_d, ph_d};
        end
    end

    // gray sequence, one count per phase change
    assign ab   = {ph_q[1], ph_q[1] ^ ph_q[0]};
    // one rising edge per step, low between bursts
    assign trig = (left_q != 3'h0) && div_q[1];
endmodule
`default_nettype wire

// ---- general_purpose_timer_tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none
module general_purpose_timer_tb_top;
    typedef struct {
        logic [7:0]  a;
        logic        w;
        logic [31:0] d;
    } row_s;
    logic        clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic        pready, pslverr, trig_out, dma_req_update, trig, err;
    logic        dbg_halt = 0, go = 0;
    logic [7:0]  paddr = '0;
    logic [31:0] pwdata = '0, prdata, r, a0, b0;
    logic [3:0]  ch_out, dma_req_cc;
    logic [1:0]  ab, cap = '0;
    logic [2:0]  hall = '0;
    logic [15:0] d;
    int          n_fail = 0, check_count = 0, n;
    int          gt [4][4] = '{'{1, 3, 1, 8}, '{2, 0, 1, 3}, '{3, 0, 5, 3}, '{4, 0, 3, 5}};
    // reset values, masking of wide writes and the unmapped hole
    row_s rows [16] = '{
        '{gpt_pkg::OFF_CTRL, 0, 0}, '{gpt_pkg::OFF_STATUS, 0, 0},
        '{gpt_pkg::OFF_CNT, 0, 0}, '{gpt_pkg::OFF_PSC, 0, 0},
        '{gpt_pkg::OFF_ARR, 0, 32'h0000ffff}, '{gpt_pkg::OFF_CHMODE, 0, 0},
        '{gpt_pkg::OFF_DMAEN, 0, 0}, '{gpt_pkg::OFF_CCR0, 0, 0},
        '{gpt_pkg::OFF_CCR0 + 8'h0c, 0, 0}, '{8'h1c, 0, 0},
        '{gpt_pkg::OFF_DMAEN, 1, 32'hffffffff}, '{gpt_pkg::OFF_DMAEN, 0, 32'h1f},
        '{gpt_pkg::OFF_PSC, 1, 32'hffffffff}, '{gpt_pkg::OFF_PSC, 0, 32'hffff},
        '{8'h1c, 1, 32'h5}, '{8'h1c, 0, 0}};

    // ****************************************
    // design, far side and clock
    // ****************************************
    general_purpose_timer DUT (.clk(clk), .rst_n(rst_n), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ch_in({cap, ab}), .ch_out(ch_out),
        .hall_in(hall), .low_speed_external_clock(1'b0), .trig_in(trig),
        .trig_out(trig_out), .dbg_halt(dbg_halt), .dma_req_update(dma_req_update),
        .dma_req_cc(dma_req_cc));
    gpt_partner ext (.clk(clk), .rst_n(rst_n), .go(go), .ab(ab), .trig(trig));

    initial forever #25 clk = ~clk;

    // ****************************************
    // shared tasks
    // ****************************************
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        check_count++;
        if (s !== e) begin
            n_fail++;
            $display("[FAIL] %0t seen %h expected %h", $time, s, e);
        end
    endtask

    // one apb transfer, held until ready is seen high
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] wd,
                       output logic [31:0] q, output logic e);
        int k = 0;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        paddr   <= a;
        pwrite  <= w;
        pwdata  <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (k >= 20) n_fail++;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] wd);
        logic [31:0] q;
        logic        e;
        apb(a, 1'b1, wd, q, e);
    endtask

    task automatic rd(input logic [7:0] a);
        logic e;
        apb(a, 1'b0, 32'h0, r, e);
    endtask

    // bounded wait for the next link pulse, returns cycles waited
    task automatic wait_trig(output int k);
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (trig_out !== 1'b1 && k < 300);
    endtask

    task automatic report_and_stop;
        if (n_fail == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    // runaway guard, well past the expected few hundred cycles
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        report_and_stop;
    end

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        foreach (rows[i]) begin
            apb(rows[i].a, rows[i].w, rows[i].d, r, err);
            if (!rows[i].w) chk(r, rows[i].d);
            chk({31'h0, err}, {31'h0, rows[i].a == 8'h1c});
        end
        wr(gpt_pkg::OFF_PSC, 0);
        // arr rises row to row so a stopped count never sits above it
        foreach (gt[i]) begin
            wr(gpt_pkg::OFF_ARR, gt[i][0]);
            wr(gpt_pkg::OFF_PSC, gt[i][1]);
            wr(gpt_pkg::OFF_CTRL, gt[i][2]);
            wait_trig(n);
            wait_trig(n);
            chk(n, gt[i][3]);
            chk({31'h0, dma_req_update}, 1);
            wr(gpt_pkg::OFF_CTRL, 0);
        end
        rd(gpt_pkg::OFF_STATUS);
        chk(r & 32'h1, 1);
        wr(gpt_pkg::OFF_STATUS, 32'hffffffff);
        rd(gpt_pkg::OFF_STATUS);
        chk(r, 0);
        // one-pulse: enable drops by itself at the update
        wr(gpt_pkg::OFF_CTRL, 32'h9);
        wait_trig(n);
        rd(gpt_pkg::OFF_CTRL);
        chk(r, 32'h8);
        // pwm on channel 0: high while next count is below 2 of 0..4
        wr(gpt_pkg::OFF_CHMODE, 32'h2);
        wr(gpt_pkg::OFF_CCR0, 32'h2);
        wr(gpt_pkg::OFF_CTRL, 32'h1);
        n = 0;
        repeat (50) begin
            @(posedge clk);
            n += ch_out[0];
        end
        chk(n, 20);
        // debug freeze holds the count, release lets it run
        wr(gpt_pkg::OFF_ARR, 32'hffff);
        wr(gpt_pkg::OFF_CTRL, 32'h11);
        dbg_halt <= 1'b1;
        repeat (3) @(posedge clk);
        rd(gpt_pkg::OFF_CNT);
        a0 = r;
        repeat (5) @(posedge clk);
        rd(gpt_pkg::OFF_CNT);
        chk(r, a0);
        dbg_halt <= 1'b0;
        rd(gpt_pkg::OFF_CNT);
        chk({31'h0, r !== a0}, 1);
        // capture on channel 2 of a stopped count
        wr(gpt_pkg::OFF_CTRL, 0);
        rd(gpt_pkg::OFF_CNT);
        a0 = r;
        cap <= 2'h1;
        repeat (4) @(posedge clk);
        rd(gpt_pkg::OFF_CCR0 + 8'h08);
        chk(r, a0);
        rd(gpt_pkg::OFF_STATUS);
        chk(r & 32'h8, 32'h8);
        // link input as clock, then quadrature input, four steps each
        for (int m = 0; m < 2; m++) begin
            wr(gpt_pkg::OFF_CTRL, m ? 32'h41 : 32'h201);
            rd(gpt_pkg::OFF_CNT);
            a0 = r;
            go <= 1'b1;
            @(posedge clk);
            go <= 1'b0;
            repeat (30) @(posedge clk);
            rd(gpt_pkg::OFF_CNT);
            d = r[15:0] - a0[15:0];
            if (!m) chk(r, a0 + 32'h4);
            else chk({31'h0, d == 16'h4 || d == 16'hfffc}, 1);
        end
        // hall transition pulls a running count far from zero back to zero
        wr(gpt_pkg::OFF_CNT, 32'h8000);
        wr(gpt_pkg::OFF_CTRL, 32'h21);
        hall <= 3'h1;
        repeat (3) @(posedge clk);
        rd(gpt_pkg::OFF_CNT);
        chk({31'h0, r < 32'h10}, 1);
        report_and_stop;
    end
endmodule
`default_nettype wire
